//--- core/acmpc_pkg.sv
`default_nettype none
package acmpc_pkg;
  typedef enum logic [1:0]
  {
    ACMPC_MODE_TOGGLE = 2'h0,
    ACMPC_MODE_RSVD   = 2'h1,
    ACMPC_MODE_FALL   = 2'h2,
    ACMPC_MODE_RISE   = 2'h3
  } acmpc_mode_t;
  typedef enum logic
  {
    ACMPC_BUS_IDLE,
    ACMPC_BUS_ACK
  } acmpc_bus_t;
endpackage
`default_nettype wire

//--- core/acmpc_regs.svh
`ifndef ACMPC_REGS_SVH
`define ACMPC_REGS_SVH
// Byte addresses of the registers on the bus
`define ACMPC_CTRL_STAT_OFS   8'h00
`define ACMPC_CONV_B_OFS      8'h04
`define ACMPC_PIN_DIS_OFS     8'h08
`define ACMPC_CONV_CHAN_OFS   8'h0C
`define ACMPC_CONV_A_OFS      8'h10
`define ACMPC_IRQ_STAT_OFS    8'h14
`define ACMPC_IRQ_MASK_OFS    8'h18
`define ACMPC_SYS_CTRL_OFS    8'h1C
// Field positions in comparator_control_status
`define ACMPC_DIS_BIT         7
`define ACMPC_BG_BIT          6
`define ACMPC_OUT_BIT         5
`define ACMPC_FLAG_BIT        4
`define ACMPC_IE_BIT          3
`define ACMPC_CAP_BIT         2
`define ACMPC_MODE_HI_BIT     1
`define ACMPC_MODE_LO_BIT     0
// Field positions in other registers
`define ACMPC_MUXEN_BIT       6
`define ACMPC_CONV_EN_BIT     7
`define ACMPC_NEG_DIS_BIT     1
`define ACMPC_POS_DIS_BIT     0
`define ACMPC_GIE_BIT         0
`define ACMPC_VEC_ACK_BIT     1
// Reset values
`define ACMPC_CTRL_RST        8'h00
`define ACMPC_CONV_B_RST      8'h00
`define ACMPC_PIN_DIS_RST     8'h00
`define ACMPC_CHAN_RST        3'h0
`define ACMPC_IRQ_RST         2'h0
// Synchroniser depth
`define ACMPC_SYNC_STAGES     2
`endif

//--- core/acmpc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module acmpc_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic [STAGES-1:0] stage_q;

  // First stage feeds only the next stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stage_q <= '0;
    else
      stage_q <= {stage_q[STAGES-2:0], async_i};
  end

  assign sync_o = stage_q[STAGES-1];
endmodule
`default_nettype wire

//--- core/acmpc_top.sv
// Contract
// - Mux on, converter off: channel drives negative
// - Otherwise dedicated negative pin drives negative
// - Disable bit powers comparator off
// - Bandgap select replaces positive input
// - Output status is synchronised, 1-2 cycles
// - Selected event sets interrupt flag
// - Flag clears on vector or write-one
// - Request needs flag, enable, global enable
// - Capture route feeds timer capture input
// - Route off: no path to capture
// - Mode: toggle, reserved, falling, rising
// - Input-disable bits gate pin buffers to zero
// - Reserved input-disable bits read zero
// - Raw result high when positive exceeds negative
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "acmpc_regs.svh"
module acmpc_top
  import acmpc_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        comparator_result_i,
  input  wire logic        positive_input_pin_i,
  input  wire logic        negative_input_pin_i,
  output logic             comparator_power_down_o,
  output logic             pos_bandgap_select_o,
  output logic             neg_use_channel_o,
  output logic [2:0]       neg_channel_o,
  output logic             capture_input_o,
  output logic             pos_pin_buffer_enable_o,
  output logic             neg_pin_buffer_enable_o,
  output logic             pos_pin_digital_o,
  output logic             neg_pin_digital_o,
  output logic             comparator_irq_o,
  output logic             irq_o
);
  logic [7:0]  ctrl_q;
  logic [7:0]  conv_b_q;
  logic [1:0]  pin_dis_q;
  logic [2:0]  channel_select_q;
  logic        converter_enable_q;
  logic        global_ie_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic        flag_q;
  logic        sync_out;
  logic        prev_q;
  logic        event_hit;
  logic        wr;
  logic        wr_ctrl;
  logic        wr_conv_b;
  logic        wr_pin_dis;
  logic        wr_chan;
  logic        wr_conv_a;
  logic        wr_irq_stat;
  logic        wr_irq_mask;
  logic        wr_sys;
  logic        rd;
  logic        vec_ack;
  logic        toggle_ev;
  logic [31:0] rd_data;
  acmpc_bus_t  bus_q;
  acmpc_mode_t mode;

  acmpc_sync #(
    .STAGES (`ACMPC_SYNC_STAGES)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (comparator_result_i),
    .sync_o  (sync_out)
  );

  // Single-cycle write strobe; ack drops the cycle after it is given
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && (bus_q == ACMPC_BUS_IDLE);
  assign rd = wb_cyc_i && wb_stb_i && (bus_q == ACMPC_BUS_IDLE);
  // Per-register write selects
  assign wr_ctrl     = wr && (wb_adr_i == `ACMPC_CTRL_STAT_OFS);
  assign wr_conv_b   = wr && (wb_adr_i == `ACMPC_CONV_B_OFS);
  assign wr_pin_dis  = wr && (wb_adr_i == `ACMPC_PIN_DIS_OFS);
  assign wr_chan     = wr && (wb_adr_i == `ACMPC_CONV_CHAN_OFS);
  assign wr_conv_a   = wr && (wb_adr_i == `ACMPC_CONV_A_OFS);
  assign wr_irq_stat = wr && (wb_adr_i == `ACMPC_IRQ_STAT_OFS);
  assign wr_irq_mask = wr && (wb_adr_i == `ACMPC_IRQ_MASK_OFS);
  assign wr_sys      = wr && (wb_adr_i == `ACMPC_SYS_CTRL_OFS);
  assign vec_ack = wr_sys && wb_dat_i[`ACMPC_VEC_ACK_BIT];
  assign mode = acmpc_mode_t'(ctrl_q[`ACMPC_MODE_HI_BIT:`ACMPC_MODE_LO_BIT]);
  assign toggle_ev = sync_out ^ prev_q;

  always_comb
  begin
    case (mode)
      ACMPC_MODE_TOGGLE: event_hit = toggle_ev;
      ACMPC_MODE_FALL:   event_hit = toggle_ev && !sync_out;
      ACMPC_MODE_RISE:   event_hit = toggle_ev && sync_out;
      default:           event_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_q <= ACMPC_BUS_IDLE;
    else if (bus_q == ACMPC_BUS_IDLE && wb_cyc_i && wb_stb_i)
      bus_q <= ACMPC_BUS_ACK;
    else
      bus_q <= ACMPC_BUS_IDLE;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= rd;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_q <= 1'b0;
    else
      prev_q <= sync_out;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= `ACMPC_CTRL_RST;
    else if (wr_ctrl)
    begin
      ctrl_q[`ACMPC_DIS_BIT] <= wb_dat_i[`ACMPC_DIS_BIT];
      ctrl_q[`ACMPC_BG_BIT]  <= wb_dat_i[`ACMPC_BG_BIT];
      ctrl_q[`ACMPC_IE_BIT]  <= wb_dat_i[`ACMPC_IE_BIT];
      ctrl_q[`ACMPC_CAP_BIT] <= wb_dat_i[`ACMPC_CAP_BIT];
      ctrl_q[`ACMPC_MODE_HI_BIT:`ACMPC_MODE_LO_BIT] <=
        wb_dat_i[`ACMPC_MODE_HI_BIT:`ACMPC_MODE_LO_BIT];
    end
  end

  // Set wins over clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_q <= 1'b0;
    else if (event_hit)
      flag_q <= 1'b1;
    else if (vec_ack || (wr_ctrl && wb_dat_i[`ACMPC_FLAG_BIT]))
      flag_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      conv_b_q <= `ACMPC_CONV_B_RST;
    else if (wr_conv_b)
      conv_b_q <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_dis_q <= 2'h0;
    else if (wr_pin_dis)
      pin_dis_q <= wb_dat_i[1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      channel_select_q <= `ACMPC_CHAN_RST;
    else if (wr_chan)
      channel_select_q <= wb_dat_i[2:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      converter_enable_q <= 1'b0;
    else if (wr_conv_a)
      converter_enable_q <= wb_dat_i[`ACMPC_CONV_EN_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      global_ie_q <= 1'b0;
    else if (wr_sys)
      global_ie_q <= wb_dat_i[`ACMPC_GIE_BIT];
  end

  // Status bit 0: comparator event, bit 1: any output change; write one clears, set wins
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_stat
      logic set_ev;
      assign set_ev = (gi == 0) ? event_hit : toggle_ev;
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          irq_stat_q[gi] <= 1'b0;
        else if (set_ev)
          irq_stat_q[gi] <= 1'b1;
        else if (wr_irq_stat && wb_dat_i[gi])
          irq_stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask_q <= `ACMPC_IRQ_RST;
    else if (wr_irq_mask)
      irq_mask_q <= wb_dat_i[1:0];
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `ACMPC_CTRL_STAT_OFS:
      begin
        rd_data[7:0] = ctrl_q;
        rd_data[`ACMPC_OUT_BIT]  = sync_out;
        rd_data[`ACMPC_FLAG_BIT] = flag_q;
      end
      `ACMPC_CONV_B_OFS:   rd_data[7:0] = conv_b_q;
      `ACMPC_PIN_DIS_OFS:  rd_data[1:0] = pin_dis_q;
      `ACMPC_CONV_CHAN_OFS: rd_data[2:0] = channel_select_q;
      `ACMPC_CONV_A_OFS:   rd_data[`ACMPC_CONV_EN_BIT] = converter_enable_q;
      `ACMPC_IRQ_STAT_OFS: rd_data[1:0] = irq_stat_q;
      `ACMPC_IRQ_MASK_OFS: rd_data[1:0] = irq_mask_q;
      `ACMPC_SYS_CTRL_OFS: rd_data[`ACMPC_GIE_BIT] = global_ie_q;
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
      wb_dat_o <= rd_data;
  end

  // Power and positive input steering, registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comparator_power_down_o <= 1'b0;
      pos_bandgap_select_o    <= 1'b0;
    end
    else
    begin
      comparator_power_down_o <= ctrl_q[`ACMPC_DIS_BIT];
      pos_bandgap_select_o    <= ctrl_q[`ACMPC_BG_BIT];
    end
  end

  // Channel reaches the negative input only with mux on and converter off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      neg_use_channel_o <= 1'b0;
      neg_channel_o     <= 3'h0;
    end
    else
    begin
      neg_use_channel_o <= conv_b_q[`ACMPC_MUXEN_BIT] && !converter_enable_q;
      neg_channel_o     <= (conv_b_q[`ACMPC_MUXEN_BIT] && !converter_enable_q)
                           ? channel_select_q : 3'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_input_o <= 1'b0;
    else
      capture_input_o <= ctrl_q[`ACMPC_CAP_BIT] && sync_out;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_pin_buffer_enable_o <= 1'b1;
      neg_pin_buffer_enable_o <= 1'b1;
    end
    else
    begin
      pos_pin_buffer_enable_o <= !pin_dis_q[`ACMPC_POS_DIS_BIT];
      neg_pin_buffer_enable_o <= !pin_dis_q[`ACMPC_NEG_DIS_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_pin_digital_o <= 1'b0;
      neg_pin_digital_o <= 1'b0;
    end
    else
    begin
      pos_pin_digital_o <= positive_input_pin_i && !pin_dis_q[`ACMPC_POS_DIS_BIT];
      neg_pin_digital_o <= negative_input_pin_i && !pin_dis_q[`ACMPC_NEG_DIS_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comparator_irq_o <= 1'b0;
      irq_o            <= 1'b0;
    end
    else
    begin
      comparator_irq_o <= flag_q && ctrl_q[`ACMPC_IE_BIT] && global_ie_q;
      irq_o            <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

//--- testbench/acmpc_comp_model.sv
`timescale 1ns/100ps
`default_nettype none
module acmpc_comp_model #(
  parameter int BG_MV  = 1100,
  parameter int NEG_MV = 500
) (
  input  wire logic [11:0] pos_mv_i,
  input  wire logic        power_down_i,
  input  wire logic        bandgap_i,
  input  wire logic        use_channel_i,
  input  wire logic [2:0]  channel_i,
  output logic             result_o
);
  int pos_v;
  int neg_v;
  always_comb
  begin
    pos_v    = bandgap_i ? BG_MV : int'(pos_mv_i);
    neg_v    = use_channel_i ? 100 * (int'(channel_i) + 1) : NEG_MV;
    result_o = !power_down_i && (pos_v > neg_v);
  end
endmodule
`default_nettype wire

//--- testbench/acmpc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module acmpc_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       comparator_result_i,
  input wire logic       positive_input_pin_i,
  input wire logic       negative_input_pin_i,
  input wire logic       neg_use_channel_o,
  input wire logic [2:0] neg_channel_o,
  input wire logic       capture_input_o,
  input wire logic       pos_pin_buffer_enable_o,
  input wire logic       neg_pin_buffer_enable_o,
  input wire logic       pos_pin_digital_o,
  input wire logic       neg_pin_digital_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_ans; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_idle; !wb_cyc_i |=> !wb_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("ack while bus idle");
  property p_chan; !neg_use_channel_o |-> neg_channel_o == 3'h0; endproperty
  a_chan: assert property (p_chan) else $error("channel set while pin selected");
  property p_pgate; !pos_pin_buffer_enable_o && $past(!pos_pin_buffer_enable_o) |-> !pos_pin_digital_o; endproperty
  a_pgate: assert property (p_pgate) else $error("positive pin not gated");
  property p_ngate; !neg_pin_buffer_enable_o && $past(!neg_pin_buffer_enable_o) |-> !neg_pin_digital_o; endproperty
  a_ngate: assert property (p_ngate) else $error("negative pin not gated");
  property p_ppass;
    pos_pin_buffer_enable_o && $past(pos_pin_buffer_enable_o) && $stable(positive_input_pin_i)
      |-> pos_pin_digital_o == positive_input_pin_i;
  endproperty
  a_ppass: assert property (p_ppass) else $error("positive pin not passed");
  property p_cap; !comparator_result_i [*4] |-> !capture_input_o; endproperty
  a_cap: assert property (p_cap) else $error("capture high with result low");
endmodule
`default_nettype wire

//--- testbench/acmpc_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "acmpc_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; $display("wrong value t=%0t got %h", $time, a); end end
module acmpc_tb_top;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_ack_o, comparator_result_i, positive_input_pin_i = 0, negative_input_pin_i = 0;
  logic        comparator_power_down_o, pos_bandgap_select_o, neg_use_channel_o, capture_input_o;
  logic [2:0]  neg_channel_o;
  logic        pos_pin_buffer_enable_o, neg_pin_buffer_enable_o, pos_pin_digital_o, neg_pin_digital_o;
  logic        comparator_irq_o, irq_o;
  logic [11:0] pos_mv = 12'h000;
  int          err_total = 0, n_compared = 0;
  always #50 clk_i = ~clk_i;
  acmpc_top acmpc_top_inst (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_dat_i                (wb_dat_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .comparator_result_i     (comparator_result_i),
    .positive_input_pin_i    (positive_input_pin_i),
    .negative_input_pin_i    (negative_input_pin_i),
    .comparator_power_down_o (comparator_power_down_o),
    .pos_bandgap_select_o    (pos_bandgap_select_o),
    .neg_use_channel_o       (neg_use_channel_o),
    .neg_channel_o           (neg_channel_o),
    .capture_input_o         (capture_input_o),
    .pos_pin_buffer_enable_o (pos_pin_buffer_enable_o),
    .neg_pin_buffer_enable_o (neg_pin_buffer_enable_o),
    .pos_pin_digital_o       (pos_pin_digital_o),
    .neg_pin_digital_o       (neg_pin_digital_o),
    .comparator_irq_o        (comparator_irq_o),
    .irq_o                   (irq_o)
  );
  acmpc_comp_model acmpc_comp_model_inst (.pos_mv_i(pos_mv), .power_down_i(comparator_power_down_o),
    .bandgap_i(pos_bandgap_select_o), .use_channel_i(neg_use_channel_o), .channel_i(neg_channel_o),
    .result_o(comparator_result_i));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    // The wait ends on ack and has no timeout of its own; only the watchdog ends a hung wait
    while (wb_ack_o !== 1'h1)
      @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'h0, a, 32'h0);
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #(100 * 5000);
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rd(`ACMPC_CTRL_STAT_OFS); `CHK(q, 32'h0)
    rd(8'h20); `CHK(q, 32'h0)
    `CHK(pos_pin_buffer_enable_o, 1'h1)
    wr(`ACMPC_CONV_B_OFS, 32'h40);
    for (int c = 0; c < 8; c++)
    begin
      wr(`ACMPC_CONV_CHAN_OFS, 32'(c));
      `CHK({neg_use_channel_o, neg_channel_o}, {1'h1, 3'(c)})
    end
    wr(`ACMPC_CONV_A_OFS, 32'h80); `CHK(neg_use_channel_o, 1'h0)
    wr(`ACMPC_CONV_B_OFS, 32'h0); wr(`ACMPC_CONV_A_OFS, 32'h0); `CHK(neg_use_channel_o, 1'h0)
    for (int m = 0; m < 4; m++)
    begin
      wr(`ACMPC_CTRL_STAT_OFS, 32'h10 | 32'(m));
      pos_mv <= 12'h3E8;
      repeat (4) @(posedge clk_i);
      rd(`ACMPC_CTRL_STAT_OFS); `CHK(q[5:4], {1'h1, 1'(m == 0 || m == 3)})
      wr(`ACMPC_CTRL_STAT_OFS, 32'h10 | 32'(m)); rd(`ACMPC_CTRL_STAT_OFS); `CHK(q[4], 1'h0)
      pos_mv <= 12'h000;
      repeat (4) @(posedge clk_i);
      rd(`ACMPC_CTRL_STAT_OFS); `CHK(q[5:4], {1'h0, 1'(m == 0 || m == 2)})
    end
    `CHK(irq_o, 1'h0)
    rd(`ACMPC_IRQ_STAT_OFS); `CHK(q, 32'h3)
    wr(`ACMPC_IRQ_MASK_OFS, 32'h2); `CHK(irq_o, 1'h1)
    wr(`ACMPC_IRQ_STAT_OFS, 32'h3); `CHK(irq_o, 1'h0)
    wr(`ACMPC_CTRL_STAT_OFS, 32'h10); wr(`ACMPC_CTRL_STAT_OFS, 32'h08); wr(`ACMPC_SYS_CTRL_OFS, 32'h1);
    pos_mv <= 12'h3E8;
    repeat (5) @(posedge clk_i);
    `CHK(comparator_irq_o, 1'h1)
    wr(`ACMPC_CTRL_STAT_OFS, 32'h08); rd(`ACMPC_CTRL_STAT_OFS); `CHK(q[4], 1'h1)
    wr(`ACMPC_CTRL_STAT_OFS, 32'h00); `CHK(comparator_irq_o, 1'h0)
    wr(`ACMPC_SYS_CTRL_OFS, 32'h3); rd(`ACMPC_CTRL_STAT_OFS); `CHK(q[4], 1'h0)
    wr(`ACMPC_CTRL_STAT_OFS, 32'h04); `CHK(capture_input_o, 1'h1)
    wr(`ACMPC_CTRL_STAT_OFS, 32'h00); `CHK(capture_input_o, 1'h0)
    positive_input_pin_i <= 1'h1;
    negative_input_pin_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    `CHK({pos_pin_digital_o, neg_pin_digital_o}, 2'h3)
    wr(`ACMPC_PIN_DIS_OFS, 32'hFF); rd(`ACMPC_PIN_DIS_OFS); `CHK(q, 32'h3)
    `CHK({pos_pin_buffer_enable_o, neg_pin_buffer_enable_o, pos_pin_digital_o, neg_pin_digital_o}, 4'h0)
    wr(`ACMPC_CTRL_STAT_OFS, 32'hC0); `CHK({comparator_power_down_o, pos_bandgap_select_o}, 2'h3)
    rd(`ACMPC_CTRL_STAT_OFS); `CHK(q[7:6], 2'h3)
    stop_test();
  end
endmodule
bind acmpc_top acmpc_monitor acmpc_monitor_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .comparator_result_i, .positive_input_pin_i, .negative_input_pin_i, .neg_use_channel_o, .neg_channel_o,
  .capture_input_o, .pos_pin_buffer_enable_o, .neg_pin_buffer_enable_o, .pos_pin_digital_o, .neg_pin_digital_o);
`default_nettype wire
